// *** rtl/dwc_pkg.sv ***
package dwc_pkg;
  // Burst encodings
  localparam logic [1:0] BURST_FIXED = 2'h0;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] BURST_WRAP = 2'h2;
  // Response encodings
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_EXOKAY = 2'h1;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int CACHE_MOD_BIT = 1;
  // Geometry: narrow side is 64 bits, wide side is narrow times ratio
  localparam int NARROW_LG = 3;
  localparam int WRAP_MAX_BEATS = 16;
  localparam logic [8:0] MAX_BEATS_SHORT = 9'h010;
  localparam logic [8:0] MAX_BEATS_LONG = 9'h100;
  localparam int ACCEPT_MAX = 32;
  localparam int GROUP_DEPTH_LG = 9;
  // Register map
  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS = 32'h0000_0004;
  localparam int CTRL_BYPASS_BIT = 0;
  localparam int CTRL_LIMIT_BIT = 1;
  localparam int CTRL_ACC_LSB = 8;
  localparam int CTRL_ACC_W = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1f00;
  localparam int STATUS_ACC_LSB = 0;
  localparam int STATUS_ISS_LSB = 16;
  localparam int STATUS_BUSY_BIT = 31;
  typedef enum logic [0:0] {
    PLAN_IDLE = 1'b0,
    PLAN_ISSUE = 1'b1
  } plan_state_e;
endpackage

// *** rtl/axi_width_converter.sv ***
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Widening ratio 1:2, 1:4 or 1:8 set by parameter.
// - Widening packs only cacheable transactions.
// - Merged responses: DECERR over SLVERR over OKAY.
// - Narrowing ratio 2:1, 4:1 or 8:1 set by parameter.
// - Widening INCR within one wide word becomes INCR1 of smallest covering size.
// - Widening INCR repacked to wide beats, sparse when unaligned; the code keeps the input size when the beat count would not drop.
// - Five-beat byte burst maps by start byte to one or two beats.
// - Widening output INCR limited to 16 beats, 256 for AXI4 to AXI4.
// - Widening 1:2 WRAP: aligned shrinks, unaligned becomes two INCRs.
// - Widening WRAP smaller than wide word becomes one INCR.
// - Widening passes FIXED unchanged.
// - Widening bypass control forwards legal transactions unaltered.
// - Widening acceptance 1..32, issuing at most twice that.
// - Narrowing never merges non-cacheable narrow data.
// - Narrowing INCR within max payload is one INCR, else split.
// - Narrowing INCR aligned to narrow not wide width gives seven beats.
// - Narrowing packs small INCR to full output-width beats, with no smallest-covering-size INCR1 as in widening.
// - Narrowing INCR limited 16/256; register restricts long bursts from AXI3.
// - Narrowing WRAP doubles up to 16 beats, else two INCRs.
// - Narrowing FIXED becomes INCR bursts per input beat.
// - Narrowing unaligned FIXED within one output beat stays FIXED, optimal size.
// - Narrowing bypass control disables packing.
// - Split exclusive clears exclusive and never returns EXOKAY.
// - Narrowing acceptance 1..32, issuing at most ratio times that plus one.
module axi_width_converter #(
  parameter bit UPSIZE = 1'b1,
  parameter int RATIO_LG = 1,
  parameter bit OUT_AXI4 = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [31:0] cmdAddr,
  input wire logic [7:0] cmdLen,
  input wire logic [2:0] cmdSize,
  input wire logic [1:0] cmdBurst,
  input wire logic [3:0] cmdCache,
  input wire logic cmdLock,
  input wire logic cmdAxi4,
  output logic outValid,
  input wire logic outReady,
  output logic [31:0] outAddr,
  output logic [7:0] outLen,
  output logic [2:0] outSize,
  output logic [1:0] outBurst,
  output logic [3:0] outCache,
  output logic outLock,
  input wire logic rspInValid,
  output logic rspInReady,
  input wire logic [1:0] rspInResp,
  output logic rspOutValid,
  input wire logic rspOutReady,
  output logic [1:0] rspOut
);
  import dwc_pkg::*;

  localparam int OL = UPSIZE ? NARROW_LG + RATIO_LG : NARROW_LG;
  localparam logic [31:0] OUT_BYTES = 32'h1 << OL;

  function automatic logic [2:0] coverLg(input logic [31:0] s, input logic [31:0] e);
    logic [2:0] r;
    r = 3'h7;
    for (int i = 7; i >= 0; i--) begin
      if ((s >> i) == (e >> i)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [11:0] words(input logic [31:0] s, input logic [31:0] e);
    return 12'((e >> OL) - (s >> OL) + 32'h1);
  endfunction

  function automatic logic [1:0] rank(input logic [1:0] r);
    return (r == RESP_DECERR) ? 2'h3 : (r == RESP_SLVERR) ? 2'h2 : (r == RESP_EXOKAY) ? 2'h1 : 2'h0;
  endfunction

  // Register file
  logic [31:0] ctrl_q;
  logic [31:0] awAddr_q, wData_q;
  logic [3:0] wStrb_q;
  logic awHave_q, wHave_q;
  logic bypass, limitLong;
  logic [5:0] accLimit;
  logic [9:0] issLimit;
  logic [5:0] accCnt_q, accCnt_d;
  logic [9:0] issCnt_q, issCnt_d;
  plan_state_e state_q, state_d;

  assign bypass = ctrl_q[CTRL_BYPASS_BIT];
  assign limitLong = ctrl_q[CTRL_LIMIT_BIT];
  assign accLimit = {1'b0, ctrl_q[CTRL_ACC_LSB +: CTRL_ACC_W]} + 6'h01;
  assign issLimit = UPSIZE ? {3'h0, accLimit, 1'b0}
                           : 10'(({4'h0, accLimit} << RATIO_LG) + 10'h001);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 32'h0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      ctrl_q <= CTRL_RESET;
    end else begin
      if (awvalid && awready) begin
        awAddr_q <= awaddr;
        awHave_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wData_q <= wdata;
        wStrb_q <= wstrb;
        wHave_q <= 1'b1;
        wready <= 1'b0;
      end
      if (awHave_q && wHave_q && !bvalid) begin
        bvalid <= 1'b1;
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        if (awAddr_q[31:2] == REG_CTRL[31:2]) begin
          bresp <= RESP_OKAY;
          if (wStrb_q[0]) begin
            ctrl_q[CTRL_LIMIT_BIT:CTRL_BYPASS_BIT] <= wData_q[CTRL_LIMIT_BIT:CTRL_BYPASS_BIT];
          end
          if (wStrb_q[1]) begin
            ctrl_q[CTRL_ACC_LSB +: CTRL_ACC_W] <= wData_q[CTRL_ACC_LSB +: CTRL_ACC_W];
          end
        end else if (awAddr_q[31:2] == REG_STATUS[31:2]) begin
          bresp <= RESP_OKAY;
        end else begin
          bresp <= RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      rdata <= 32'h0;
      if (araddr[31:2] == REG_CTRL[31:2]) begin
        rdata <= ctrl_q;
      end else if (araddr[31:2] == REG_STATUS[31:2]) begin
        rdata[STATUS_ACC_LSB +: 6] <= accCnt_q;
        rdata[STATUS_ISS_LSB +: 10] <= issCnt_q;
        rdata[STATUS_BUSY_BIT] <= (state_q == PLAN_ISSUE);
      end else begin
        rresp <= RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Transaction planning from the incoming command
  logic pack;
  logic [31:0] total, alStart, endA, wBase, wEnd, beatEnd;
  logic [31:0] pAddr, p2Addr;
  logic [11:0] pBeats, p2Beats;
  logic [2:0] pSize;
  logic [1:0] pBurst;
  logic pHas2, pSplit;
  logic [7:0] pRep;
  logic [8:0] pMax;

  always_comb begin
    pack = cmdCache[CACHE_MOD_BIT] && !bypass;
    total = ({24'h0, cmdLen} + 32'h1) << cmdSize;
    alStart = cmdAddr & ~((32'h1 << cmdSize) - 32'h1);
    endA = alStart + total - 32'h1;
    wBase = cmdAddr & ~(total - 32'h1);
    wEnd = wBase + total - 32'h1;
    beatEnd = alStart + (32'h1 << cmdSize) - 32'h1;
    pAddr = cmdAddr;
    pBeats = {4'h0, cmdLen} + 12'h001;
    pSize = cmdSize;
    pBurst = cmdBurst;
    p2Addr = 32'h0;
    p2Beats = 12'h000;
    pHas2 = 1'b0;
    pRep = 8'h00;
    if (UPSIZE) begin
      // FIXED and unpacked traffic fall through unchanged
      if (cmdBurst == BURST_INCR && pack) begin
        pSize = 3'(OL);
        if ((cmdAddr >> OL) == (endA >> OL)) begin
          pSize = coverLg(cmdAddr, endA);
          pBeats = 12'h001;
        end else begin
          pBeats = words(cmdAddr, endA);
          if (pBeats == {4'h0, cmdLen} + 12'h001) pSize = cmdSize;
        end
      end else if (cmdBurst == BURST_WRAP && pack) begin
        pSize = 3'(OL);
        if (total <= OUT_BYTES) begin
          pAddr = wBase;
          pSize = coverLg(wBase, wEnd);
          pBeats = 12'h001;
          pBurst = BURST_INCR;
        end else if ((alStart & (OUT_BYTES - 32'h1)) == 32'h0) begin
          pBeats = 12'(total >> OL);
        end else begin
          pBurst = BURST_INCR;
          pBeats = words(alStart, wEnd);
          p2Addr = wBase;
          p2Beats = words(wBase, alStart - 32'h1);
          pHas2 = 1'b1;
        end
      end
    end else begin
      if (cmdBurst == BURST_FIXED) begin
        if ((cmdAddr >> OL) == (beatEnd >> OL)) begin
          pSize = coverLg(cmdAddr, beatEnd);
        end else begin
          pBurst = BURST_INCR;
          pSize = 3'(OL);
          pBeats = words(cmdAddr, beatEnd);
          pRep = cmdLen;
        end
      end else if (32'(cmdSize) > 32'(OL) || pack) begin
        pSize = 3'(OL);
        if (cmdBurst == BURST_INCR) begin
          pBeats = words(cmdAddr, endA);
        end else if (alStart == wBase || total <= OUT_BYTES) begin
          pAddr = wBase;
          pBurst = BURST_INCR;
          pBeats = words(wBase, wEnd);
        end else if ((total >> OL) <= 32'(WRAP_MAX_BEATS)) begin
          pBeats = 12'(total >> OL);
        end else begin
          pBurst = BURST_INCR;
          pBeats = words(alStart, wEnd);
          p2Addr = wBase;
          p2Beats = words(wBase, alStart - 32'h1);
          pHas2 = 1'b1;
        end
      end
    end
    // Long bursts only between AXI4 ends; from AXI3 only when narrowing unrestricted
    pMax = (OUT_AXI4 && (cmdAxi4 || (!UPSIZE && !limitLong))) ? MAX_BEATS_LONG : MAX_BEATS_SHORT;
    pSplit = pHas2 || (pRep != 8'h00) || (pBeats > {3'h0, pMax});
  end

  // Issue sequencer
  logic [31:0] segAddr_q, seg2Addr_q, fixAddr_q;
  logic [11:0] segBeats_q, seg2Beats_q, fixBeats_q;
  logic [2:0] segSize_q;
  logic [1:0] segBurst_q;
  logic [3:0] cache_q;
  logic has2_q, lock_q, pieceLast_q;
  logic [7:0] rep_q;
  logic [8:0] max_q;
  logic [11:0] n;
  logic nowLast, accept, outFire, inFire, rspFire, load;

  always_comb begin
    accept = cmdValid && cmdReady;
    outFire = outValid && outReady;
    inFire = rspInValid && rspInReady;
    rspFire = rspOutValid && rspOutReady;
    n = (segBeats_q > {3'h0, max_q}) ? {3'h0, max_q} : segBeats_q;
    nowLast = (segBeats_q == n) && !has2_q && (rep_q == 8'h00);
    load = (state_q == PLAN_ISSUE) && !outValid && (issCnt_q < issLimit);
    accCnt_d = accCnt_q + {5'h00, accept} - {5'h00, rspFire};
    issCnt_d = issCnt_q + {9'h000, outFire} - {9'h000, inFire};
    state_d = state_q;
    case (state_q)
      PLAN_IDLE: begin
        if (accept) begin
          state_d = PLAN_ISSUE;
        end
      end
      PLAN_ISSUE: begin
        if (outFire && pieceLast_q) begin
          state_d = PLAN_IDLE;
        end
      end
      default: state_d = PLAN_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= PLAN_IDLE;
      accCnt_q <= 6'h00;
      issCnt_q <= 10'h000;
      cmdReady <= 1'b0;
    end else begin
      state_q <= state_d;
      accCnt_q <= accCnt_d;
      issCnt_q <= issCnt_d;
      cmdReady <= (state_d == PLAN_IDLE) && (accCnt_d < accLimit);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      segAddr_q <= 32'h0;
      seg2Addr_q <= 32'h0;
      fixAddr_q <= 32'h0;
      segBeats_q <= 12'h000;
      seg2Beats_q <= 12'h000;
      fixBeats_q <= 12'h000;
      segSize_q <= 3'h0;
      segBurst_q <= BURST_INCR;
      cache_q <= 4'h0;
      has2_q <= 1'b0;
      lock_q <= 1'b0;
      rep_q <= 8'h00;
      max_q <= MAX_BEATS_SHORT;
    end else if (accept) begin
      segAddr_q <= pAddr;
      fixAddr_q <= pAddr;
      segBeats_q <= pBeats;
      fixBeats_q <= pBeats;
      seg2Addr_q <= p2Addr;
      seg2Beats_q <= p2Beats;
      segSize_q <= pSize;
      segBurst_q <= pBurst;
      cache_q <= cmdCache;
      has2_q <= pHas2;
      rep_q <= pRep;
      max_q <= pMax;
      lock_q <= cmdLock && !pSplit;
    end else if (load) begin
      if (segBeats_q != n) begin
        segBeats_q <= segBeats_q - n;
        segAddr_q <= (segAddr_q & ~((32'h1 << segSize_q) - 32'h1)) + ({20'h0, n} << segSize_q);
      end else if (has2_q) begin
        segAddr_q <= seg2Addr_q;
        segBeats_q <= seg2Beats_q;
        has2_q <= 1'b0;
      end else if (rep_q != 8'h00) begin
        rep_q <= rep_q - 8'h01;
        segAddr_q <= fixAddr_q;
        segBeats_q <= fixBeats_q;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      outValid <= 1'b0;
      outAddr <= 32'h0;
      outLen <= 8'h00;
      outSize <= 3'h0;
      outBurst <= BURST_INCR;
      outCache <= 4'h0;
      outLock <= 1'b0;
      pieceLast_q <= 1'b0;
    end else if (load) begin
      outValid <= 1'b1;
      outAddr <= segAddr_q;
      outLen <= 8'(n - 12'h001);
      outSize <= segSize_q;
      outBurst <= segBurst_q;
      outCache <= cache_q;
      outLock <= lock_q;
      pieceLast_q <= nowLast;
    end else if (outFire) begin
      outValid <= 1'b0;
    end
  end

  // Group boundaries of issued pieces, consumed in response order
  logic grpLast_q [0:(1 << GROUP_DEPTH_LG) - 1];
  logic [GROUP_DEPTH_LG-1:0] wrPtr_q, rdPtr_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
    end else if (outFire) begin
      wrPtr_q <= wrPtr_q + 9'h001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (outFire) begin
      grpLast_q[wrPtr_q] <= pieceLast_q;
    end
  end

  // Response merge
  logic [1:0] merge_q, r, worst;
  logic many_q;

  always_comb begin
    r = (many_q && rspInResp == RESP_EXOKAY) ? RESP_OKAY : rspInResp;
    worst = (rank(r) > rank(merge_q)) ? r : merge_q;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdPtr_q <= '0;
      merge_q <= RESP_OKAY;
      many_q <= 1'b0;
      rspInReady <= 1'b1;
      rspOutValid <= 1'b0;
      rspOut <= RESP_OKAY;
    end else begin
      if (inFire) begin
        rdPtr_q <= rdPtr_q + 9'h001;
        if (grpLast_q[rdPtr_q]) begin
          rspOutValid <= 1'b1;
          rspInReady <= 1'b0;
          rspOut <= worst;
          merge_q <= RESP_OKAY;
          many_q <= 1'b0;
        end else begin
          merge_q <= (worst == RESP_EXOKAY) ? RESP_OKAY : worst;
          many_q <= 1'b1;
        end
      end
      if (rspFire) begin
        rspOutValid <= 1'b0;
        rspInReady <= 1'b1;
      end
    end
  end
endmodule // axi_width_converter
`default_nettype wire

// *** verification/axi_width_converter_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module axi_width_converter_checker
  import dwc_pkg::*;
#(
  parameter bit UPSIZE = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic [31:0] cmdAddr,
  input wire logic [7:0] cmdLen,
  input wire logic [2:0] cmdSize,
  input wire logic [1:0] cmdBurst,
  input wire logic [3:0] cmdCache,
  input wire logic cmdAxi4,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [31:0] outAddr,
  input wire logic [7:0] outLen,
  input wire logic [2:0] outSize,
  input wire logic [1:0] outBurst,
  input wire logic outLock,
  input wire logic rspInValid,
  input wire logic rspInReady,
  input wire logic [1:0] rspInResp,
  input wire logic rspOutValid,
  input wire logic rspOutReady,
  input wire logic [1:0] rspOut
);
  logic [31:0] addrQ;
  logic [7:0] lenQ;
  logic [2:0] sizeQ;
  logic [1:0] burstQ, worstQ;
  logic cacheQ, axi4Q;
  logic [8:0] pcsQ, nRspQ;
  logic [6:0] accQ;
  logic [9:0] issQ;
  wire logic cmdFire = cmdValid && cmdReady;
  wire logic outFire = outValid && outReady;
  wire logic inFire = rspInValid && rspInReady;
  wire logic rspFire = rspOutValid && rspOutReady;
  always_ff @(posedge clk_sys) begin
    if (cmdFire) begin
      addrQ <= cmdAddr;
      lenQ <= cmdLen;
      sizeQ <= cmdSize;
      burstQ <= cmdBurst;
      cacheQ <= cmdCache[CACHE_MOD_BIT];
      axi4Q <= cmdAxi4;
    end
  end
  // Piece index, merged response and outstanding counts
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pcsQ <= '0;
      nRspQ <= '0;
      worstQ <= RESP_OKAY;
      accQ <= '0;
      issQ <= '0;
    end else begin
      pcsQ <= cmdFire ? 9'h000 : pcsQ + 9'(outFire);
      accQ <= accQ + 7'(cmdFire) - 7'(rspFire);
      issQ <= issQ + 10'(outFire) - 10'(inFire);
      if (rspFire) begin
        nRspQ <= '0;
        worstQ <= RESP_OKAY;
      end else if (inFire) begin
        nRspQ <= nRspQ + 9'h001;
        worstQ <= (rspInResp > worstQ) ? rspInResp : worstQ;
      end
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_out_hold: assert property (outValid && !outReady |=> outValid && $stable({outAddr, outLen, outSize, outBurst}))
    else $error("converted command changed while waiting");
  a_cmd_gap: assert property (cmdFire |=> !cmdReady)
    else $error("command ready not dropped after take");
  a_split_unlocked: assert property (outFire && pcsQ != 9'h000 |-> !outLock)
    else $error("exclusive kept on split piece");
  a_len_short: assert property (outValid && !axi4Q |-> outLen <= 8'h0f)
    else $error("piece from short source over 16 beats");
  a_fixed_pass: assert property (UPSIZE && outValid && burstQ == BURST_FIXED |->
    outBurst == BURST_FIXED && outLen == lenQ && outSize == sizeQ && outAddr == addrQ)
    else $error("fixed burst altered");
  a_uncached_size: assert property (UPSIZE && outValid && burstQ == BURST_INCR && !cacheQ |-> outSize == sizeQ)
    else $error("non-cacheable burst packed");
  a_resp_merge: assert property ($rose(rspOutValid) |->
    rspOut == ((worstQ == RESP_EXOKAY && nRspQ > 9'h001) ? RESP_OKAY : worstQ))
    else $error("merged response wrong");
  a_rsp_hold: assert property (rspOutValid && !rspOutReady |=> rspOutValid && $stable(rspOut))
    else $error("response dropped before taken");
  a_caps: assert property (accQ <= 7'(ACCEPT_MAX) && issQ <= 10'(2 * ACCEPT_MAX))
    else $error("outstanding count over capability");
endmodule // axi_width_converter_checker
bind axi_width_converter axi_width_converter_checker #(.UPSIZE(UPSIZE)) axi_width_converter_checker_i (
  .clk_sys, .rst, .cmdValid, .cmdReady, .cmdAddr, .cmdLen, .cmdSize, .cmdBurst, .cmdCache, .cmdAxi4,
  .outValid, .outReady, .outAddr, .outLen, .outSize, .outBurst, .outLock,
  .rspInValid, .rspInReady, .rspInResp, .rspOutValid, .rspOutReady, .rspOut);
`default_nettype wire

// *** verification/dwc_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dwc_far_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic slow,
  input wire logic hold,
  input wire logic [3:0] codes,
  input wire logic outValid,
  output logic outReady,
  output logic rspInValid,
  input wire logic rspInReady,
  output logic [1:0] rspInResp
);
  logic [7:0] pend;
  logic idx, tick;
  // Slow mode takes a piece every other cycle
  assign outReady = !slow || tick;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend <= '0;
      idx <= 1'b0;
      tick <= 1'b0;
      rspInValid <= 1'b0;
      rspInResp <= 2'h0;
    end else begin
      tick <= !tick;
      pend <= pend + 8'(outValid && outReady) - 8'(rspInValid && rspInReady);
      if (rspInValid && rspInReady) begin
        rspInValid <= 1'b0;
        // Released lines change value
        rspInResp <= ~rspInResp;
        idx <= (pend != 8'h01);
      end else if (!rspInValid && !hold && pend != 8'h00) begin
        rspInValid <= 1'b1;
        rspInResp <= idx ? codes[3:2] : codes[1:0];
      end
    end
  end
endmodule // dwc_far_model
`default_nettype wire

// *** verification/axi_data_width_converter_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module axi_data_width_converter_bench;
  import dwc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, cmdAddr = '0, rdata, outAddr;
  logic [3:0] wstrb = 4'hf, cmdCache = '0, codes = '0, outCache;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic cmdValid = 1'b0, cmdLock = 1'b0, cmdAxi4 = 1'b1, rspOutReady = 1'b1, hold = 1'b0, slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cmdReady, outValid, outReady, outLock;
  logic rspInValid, rspInReady, rspOutValid;
  logic [1:0] bresp, rresp, rspInResp, rspOut, cmdBurst = '0, outBurst;
  logic [7:0] cmdLen = '0, outLen;
  logic [2:0] cmdSize = '0, outSize;
  int checks = 0, n_fail = 0, cyc = 0;
  always #25 clk_sys = ~clk_sys;
  axi_width_converter #(.UPSIZE(1'b1), .RATIO_LG(1), .OUT_AXI4(1'b1)) axi_width_converter_i (
    .clk_sys, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cmdValid, .cmdReady, .cmdAddr, .cmdLen,
    .cmdSize, .cmdBurst, .cmdCache, .cmdLock, .cmdAxi4, .outValid, .outReady, .outAddr, .outLen, .outSize,
    .outBurst, .outCache, .outLock, .rspInValid, .rspInReady, .rspInResp, .rspOutValid, .rspOutReady, .rspOut);
  dwc_far_model dwc_far_model_i (.clk_sys, .rst, .slow, .hold, .codes, .outValid, .outReady,
    .rspInValid, .rspInReady, .rspInResp);
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // Bus tasks start and end just after a rising edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!tb) begin
      @(negedge clk_sys);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb) chk("bresp", er, bresp);
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic ta, t;
    t = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!t) begin
      @(negedge clk_sys);
      ta = arvalid && arready;
      t = rvalid;
      if (t) chk("rdata", e, rdata & m);
      if (t) chk("rresp", er, rresp);
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
    end
  endtask
  task automatic cmd(input logic [31:0] a, input logic [7:0] l, input logic [2:0] s, input logic [1:0] b,
      input logic [3:0] c, input logic k);
    logic t;
    t = 1'b0;
    cmdAddr <= a;
    cmdLen <= l;
    cmdSize <= s;
    cmdBurst <= b;
    cmdCache <= c;
    cmdLock <= k;
    cmdValid <= 1'b1;
    while (!t) begin
      @(negedge clk_sys);
      t = cmdReady;
      @(posedge clk_sys);
    end
    cmdValid <= 1'b0;
  endtask
  task automatic piece(input logic [7:0] l, input logic [2:0] s, input logic [1:0] b, input logic k);
    logic t;
    t = 1'b0;
    while (!t) begin
      @(negedge clk_sys);
      t = outValid && outReady;
      if (t) chk("outLen", l, outLen);
      if (t) chk("outSize", s, outSize);
      if (t) chk("outBurst", b, outBurst);
      if (t) chk("outLock", k, outLock);
      if (t) chk("outCache", cmdCache, outCache);
      @(posedge clk_sys);
    end
  endtask
  task automatic rsp(input logic [1:0] er);
    logic t;
    t = 1'b0;
    while (!t) begin
      @(negedge clk_sys);
      t = rspOutValid && rspOutReady;
      if (t) chk("rspOut", er, rspOut);
      @(posedge clk_sys);
    end
  endtask
  task automatic one(input logic [31:0] a, input logic [7:0] l, input logic [2:0] s, input logic [1:0] b,
      input logic [3:0] c, input logic k, input logic [7:0] el, input logic [2:0] es, input logic [1:0] eb,
      input logic [1:0] er);
    cmd(a, l, s, b, c, k);
    piece(el, es, eb, k);
    rsp(er);
  endtask
  // Unaligned wrap from byte 8 splits into two pieces
  task automatic split(input logic [3:0] cd, input logic [1:0] er);
    hold <= 1'b1;
    codes <= cd;
    rspOutReady <= 1'b0;
    cmd(32'h0000_0008, 8'h03, 3'h3, BURST_WRAP, 4'h2, 1'b1);
    piece(8'h01, 3'h4, BURST_INCR, 1'b0);
    piece(8'h00, 3'h4, BURST_INCR, 1'b0);
    hold <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rspOutReady <= 1'b1;
    rsp(er);
  endtask
  task automatic done(input string n);
    $display("test %s complete", n);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(REG_CTRL, '1, CTRL_RESET, RESP_OKAY);
    rd(32'h0000_0010, '1, 32'h0, RESP_SLVERR);
    wr(32'h0000_0010, 32'h0000_0001, RESP_SLVERR);
    wr(REG_STATUS, '1, RESP_OKAY);
    rd(REG_STATUS, 32'h03ff_003f, 32'h0, RESP_OKAY);
    rd(REG_CTRL, '1, CTRL_RESET, RESP_OKAY);
    done("registers");
    one(32'h0, 8'h00, 3'h3, BURST_INCR, 4'h2, 1'b0, 8'h00, 3'h3, BURST_INCR, RESP_OKAY);
    one(32'h0, 8'h01, 3'h3, BURST_INCR, 4'h2, 1'b0, 8'h00, 3'h4, BURST_INCR, RESP_OKAY);
    one(32'h0, 8'h07, 3'h0, BURST_INCR, 4'h2, 1'b0, 8'h00, 3'h3, BURST_INCR, RESP_OKAY);
    one(32'h1, 8'h04, 3'h0, BURST_INCR, 4'h2, 1'b0, 8'h00, 3'h3, BURST_INCR, RESP_OKAY);
    slow <= 1'b1;
    cmdAxi4 <= 1'b0;
    one(32'h8, 8'h01, 3'h3, BURST_INCR, 4'h2, 1'b0, 8'h01, 3'h3, BURST_INCR, RESP_OKAY);
    one(32'h0, 8'h03, 3'h3, BURST_INCR, 4'h2, 1'b0, 8'h01, 3'h4, BURST_INCR, RESP_OKAY);
    one(32'h8, 8'h03, 3'h3, BURST_INCR, 4'h2, 1'b0, 8'h02, 3'h4, BURST_INCR, RESP_OKAY);
    one(32'h0, 8'h03, 3'h3, BURST_INCR, 4'h0, 1'b0, 8'h03, 3'h3, BURST_INCR, RESP_OKAY);
    one(32'h8, 8'h03, 3'h3, BURST_FIXED, 4'h2, 1'b0, 8'h03, 3'h3, BURST_FIXED, RESP_OKAY);
    one(32'h0, 8'h01, 3'h3, BURST_WRAP, 4'h2, 1'b0, 8'h00, 3'h4, BURST_INCR, RESP_OKAY);
    one(32'h0, 8'h03, 3'h3, BURST_WRAP, 4'h2, 1'b0, 8'h01, 3'h4, BURST_WRAP, RESP_OKAY);
    slow <= 1'b0;
    cmdAxi4 <= 1'b1;
    one(32'h0, 8'h28, 3'h3, BURST_INCR, 4'h2, 1'b0, 8'h14, 3'h4, BURST_INCR, RESP_OKAY);
    codes <= 4'h1;
    one(32'h0, 8'h03, 3'h3, BURST_INCR, 4'h2, 1'b1, 8'h01, 3'h4, BURST_INCR, RESP_EXOKAY);
    done("conversion");
    split({RESP_EXOKAY, RESP_EXOKAY}, RESP_OKAY);
    split({RESP_SLVERR, RESP_DECERR}, RESP_DECERR);
    split({RESP_SLVERR, RESP_OKAY}, RESP_SLVERR);
    codes <= 4'h0;
    done("split");
    wr(REG_CTRL, 32'h0000_1f01, RESP_OKAY);
    rd(REG_CTRL, '1, 32'h0000_1f01, RESP_OKAY);
    one(32'h0, 8'h03, 3'h3, BURST_INCR, 4'h2, 1'b0, 8'h03, 3'h3, BURST_INCR, RESP_OKAY);
    done("bypass");
    wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    hold <= 1'b1;
    cmd(32'h0, 8'h03, 3'h3, BURST_INCR, 4'h2, 1'b0);
    piece(8'h01, 3'h4, BURST_INCR, 1'b0);
    rd(REG_STATUS, 32'h03ff_003f, 32'h0001_0001, RESP_OKAY);
    @(negedge clk_sys);
    chk("cmdReady", 32'h0, cmdReady);
    @(posedge clk_sys);
    hold <= 1'b0;
    rsp(RESP_OKAY);
    one(32'h0, 8'h01, 3'h3, BURST_INCR, 4'h2, 1'b0, 8'h00, 3'h4, BURST_INCR, RESP_OKAY);
    wr(REG_CTRL, CTRL_RESET, RESP_OKAY);
    done("acceptance");
    close_out();
  end
endmodule // axi_data_width_converter_bench
`default_nettype wire
